// ==== qld_link_model.sv ====
/*
  qld_link_model: line side stand-in, cause detectors and remote partner.
  assumes: bench sets request levels, registered here on the clock.
*/
`timescale 1ns/1ps
`default_nettype none
module qld_link_model
  import qld_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [4:0] cause_req_in,
  input wire logic drop_in,
  input wire logic [QLD_THR_W-1:0] acc_req_in,
  input wire logic sig_req_in,
  input wire logic force_in,
  output qld_cause_s cause_out,
  output logic [QLD_THR_W-1:0] acc_out,
  output logic sig_out,
  output logic partner_up_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cause_out <= '0;
      acc_out <= '1;
      sig_out <= 1'b1;
      partner_up_out <= 1'b1;
    end else begin
      cause_out <= {cause_req_in[4:1], drop_in};
      acc_out <= acc_req_in;
      sig_out <= sig_req_in;
      partner_up_out <= !force_in; // remote side drops while forced
    end
  end
endmodule
`default_nettype wire

// ==== qld_neg_timer.sv ====
/*
  qld_neg_timer: serial negotiation timer, counts the selected duration after a start pulse.
  assumes: start is a one-cycle pulse; a new start restarts the count.
*/
`timescale 1ns/1ps
`default_nettype none
module qld_neg_timer
  import qld_pkg::*;
#(
  parameter int unsigned T11MS_CYC = QLD_T11MS_CYC,
  parameter int unsigned T800US_CYC = QLD_T800US_CYC,
  parameter int unsigned T2US_CYC = QLD_T2US_CYC,
  parameter int unsigned T16MS_CYC = QLD_T16MS_CYC
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic start_in,
  input wire logic [QLD_TIMER_W-1:0] sel_in,
  output logic done_out
);
  initial begin
    if (T16MS_CYC >= (1 << QLD_TMR_W) || T11MS_CYC >= (1 << QLD_TMR_W) ||
        T2US_CYC < 1 || T800US_CYC < 1) begin
      $error("qld_neg_timer: timer count out of range");
    end
  end

  function automatic logic [QLD_TMR_W-1:0] load_of(input logic [QLD_TIMER_W-1:0] s);
    if (s == QLD_TIMER_11MS) begin
      load_of = QLD_TMR_W'(T11MS_CYC);
    end else if (s == QLD_TIMER_800US) begin
      load_of = QLD_TMR_W'(T800US_CYC);
    end else if (s == QLD_TIMER_2US) begin
      load_of = QLD_TMR_W'(T2US_CYC);
    end else begin
      load_of = QLD_TMR_W'(T16MS_CYC);
    end
  endfunction

  logic [QLD_TMR_W-1:0] count;
  logic [QLD_TMR_W-1:0] next_count;
  logic running;
  logic next_running;
  logic next_done;

  always_comb begin
    next_count = count;
    next_running = running;
    next_done = 1'b0;
    if (start_in) begin
      next_count = load_of(sel_in);
      next_running = 1'b1;
    end else if (running) begin
      if (count == QLD_TMR_W'(1)) begin
        next_running = 1'b0;
        next_done = 1'b1;
      end
      next_count = count - QLD_TMR_W'(1);
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count <= '0;
      running <= 1'b0;
      done_out <= 1'b0;
    end else begin
      count <= next_count;
      running <= next_running;
      done_out <= next_done;
    end
  end
endmodule
`default_nettype wire

// ==== qld_pkg.sv ====
/*
  qld_pkg: register map, field layout, reset values and carriers for the quick link drop
  configuration block.
  assumes: included before every design file of the block.
*/
`default_nettype none
package qld_pkg;
  localparam int unsigned QLD_DATA_W = 32;
  localparam int unsigned QLD_ADDR_W = 12;
  localparam int unsigned QLD_CAUSE_W = 5;
  localparam int unsigned QLD_THR_W = 3;
  localparam int unsigned QLD_TIMER_W = 2;
  // printed offsets are register indices, byte address is index times four
  localparam logic [QLD_ADDR_W-1:0] QLD_IDX_CFG = 12'h02D;
  localparam logic [QLD_ADDR_W-1:0] QLD_IDX_THR = 12'h02E;
  localparam logic [QLD_ADDR_W-1:0] QLD_IDX_CONFIG_FOUR = 12'h031;
  localparam logic [QLD_ADDR_W-1:0] QLD_IDX_IRQ_STS = 12'h040;
  localparam logic [QLD_ADDR_W-1:0] QLD_IDX_IRQ_MASK = 12'h041;
  localparam int unsigned QLD_BYTE_SHIFT = 2;
  // link_drop_config fields
  localparam int unsigned QLD_CFG_FORCE_BIT = 15;
  localparam int unsigned QLD_CFG_EN_BIT = 14;
  localparam int unsigned QLD_CFG_LATCH_LSB = 8;
  localparam int unsigned QLD_CFG_SRC_LSB = 0;
  // link_drop_threshold fields
  localparam int unsigned QLD_THR_RSVA_LSB = 8;
  localparam int unsigned QLD_THR_RSVB_LSB = 4;
  localparam int unsigned QLD_THR_LSB = 0;
  localparam logic [QLD_THR_W-1:0] QLD_THR_RESET = 3'h1;
  localparam logic [QLD_THR_W-1:0] QLD_THR_STRAP_RESET = 3'h2;
  localparam logic [QLD_THR_W-1:0] QLD_THR_RSV_RESET = 3'h2;
  // config_four fields
  localparam int unsigned QLD_C4_RSV8_BIT = 8;
  localparam int unsigned QLD_C4_TEST_BIT = 7;
  localparam int unsigned QLD_C4_TIMER_LSB = 5;
  localparam int unsigned QLD_C4_MIRROR_BIT = 0;
  localparam logic [QLD_TIMER_W-1:0] QLD_TIMER_RESET = 2'h1;
  localparam logic [15:0] QLD_C4_FIXED = 16'h1010;
  localparam logic [QLD_TIMER_W-1:0] QLD_TIMER_11MS = 2'h3;
  localparam logic [QLD_TIMER_W-1:0] QLD_TIMER_800US = 2'h2;
  localparam logic [QLD_TIMER_W-1:0] QLD_TIMER_2US = 2'h1;
  // negotiation timer durations in microseconds and in clock cycles
  localparam int unsigned QLD_CLK_MHZ = 100;
  localparam int unsigned QLD_T11MS_US = 11000;
  localparam int unsigned QLD_T800US_US = 800;
  localparam int unsigned QLD_T2US_US = 2;
  localparam int unsigned QLD_T16MS_US = 16000;
  localparam int unsigned QLD_T11MS_CYC = QLD_T11MS_US * QLD_CLK_MHZ;
  localparam int unsigned QLD_T800US_CYC = QLD_T800US_US * QLD_CLK_MHZ;
  localparam int unsigned QLD_T2US_CYC = QLD_T2US_US * QLD_CLK_MHZ;
  localparam int unsigned QLD_T16MS_CYC = QLD_T16MS_US * QLD_CLK_MHZ;
  localparam int unsigned QLD_TMR_W = 21;
  // cause bit positions inside the five-bit fields
  localparam int unsigned QLD_C_DESCR = 4;
  localparam int unsigned QLD_C_RXERR = 3;
  localparam int unsigned QLD_C_MLT3 = 2;
  localparam int unsigned QLD_C_SNR = 1;
  localparam int unsigned QLD_C_ENERGY = 0;
  // interrupt status and mask layout
  localparam int unsigned QLD_IRQ_W = 6;
  localparam int unsigned QLD_IRQ_TMR_BIT = 5;

  typedef struct packed {
    logic descr_loss;
    logic rx_err;
    logic mlt3_err;
    logic snr_low;
    logic link_drop;
  } qld_cause_s;

  typedef struct packed {
    logic force_partner_drop;
    logic quick_drop_active;
    logic test_mode;
    logic mirror;
    logic timer_done;
  } qld_ctrl_s;
endpackage
`default_nettype wire

// ==== qld_regs.sv ====
/*
  qld_regs: APB register bank for quick link drop configuration, cause latching,
  energy threshold compare, test mode, negotiation timer select and pair mirroring.
  assumes: one 100 MHz clock, asynchronous active-low reset, cause inputs and straps
  synchronous to the clock; cause detectors live outside.
*/
`timescale 1ns/1ps
`default_nettype none
module qld_regs
  import qld_pkg::*;
#(
  parameter int unsigned T11MS_CYC = QLD_T11MS_CYC,
  parameter int unsigned T800US_CYC = QLD_T800US_CYC,
  parameter int unsigned T2US_CYC = QLD_T2US_CYC,
  parameter int unsigned T16MS_CYC = QLD_T16MS_CYC
) (
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [QLD_ADDR_W+1:0] PADDR_IN,
  input wire logic [QLD_DATA_W-1:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic PREADY_OUT,
  output logic [QLD_DATA_W-1:0] PRDATA_OUT,
  output logic PSLVERR_OUT,
  input wire qld_cause_s CAUSE_IN,
  input wire logic [QLD_THR_W-1:0] ENERGY_ACC_IN,
  input wire logic SIGNAL_DETECT_IN,
  input wire logic QUICK_DROP_STRAP_IN,
  input wire logic TEST_MODE_STRAP_IN,
  input wire logic MIRROR_STRAP_IN,
  input wire logic NEG_TIMER_START_IN,
  output qld_ctrl_s CTRL_OUT,
  output logic [QLD_CAUSE_W-1:0] CAUSE_LATCH_OUT,
  output logic IRQ_OUT
);
  typedef enum logic [1:0] {QLD_IDLE, QLD_STRAP, QLD_RUN} qld_phase_e;

  function automatic logic [QLD_CAUSE_W-1:0] cause_vec(input qld_cause_s c, input logic e);
    cause_vec = {c.descr_loss, c.rx_err, c.mlt3_err, c.snr_low, e};
  endfunction

  function automatic logic [QLD_DATA_W-1:0] word_of(input logic [15:0] w);
    word_of = QLD_DATA_W'(w);
  endfunction

  function automatic logic [QLD_DATA_W-1:0] irq_word(input logic [QLD_IRQ_W-1:0] v);
    irq_word = QLD_DATA_W'(v);
  endfunction

  initial begin
    if (T2US_CYC < 1 || T800US_CYC < 1 || T11MS_CYC < 1 || T16MS_CYC < 1) begin
      $error("qld_regs: timer counts must be at least one");
    end
  end

  qld_phase_e phase;
  qld_phase_e next_phase;
  logic force_drop, next_force_drop;
  logic drop_en, next_drop_en;
  logic [QLD_CAUSE_W-1:0] latch, next_latch;
  logic [QLD_CAUSE_W-1:0] src_sel, next_src_sel;
  logic [QLD_THR_W-1:0] thr, next_thr;
  logic [QLD_THR_W-1:0] thr_rsva, next_thr_rsva;
  logic [QLD_THR_W-1:0] thr_rsvb, next_thr_rsvb;
  logic c4_rsv8, next_c4_rsv8;
  logic test_one, next_test_one;
  logic [QLD_TIMER_W-1:0] neg_sel, next_neg_sel;
  logic mirror, next_mirror;
  logic [QLD_IRQ_W-1:0] irq_sts, next_irq_sts;
  logic [QLD_IRQ_W-1:0] irq_mask, next_irq_mask;
  logic pready, next_pready;
  logic [QLD_DATA_W-1:0] prdata, next_prdata;
  logic pslverr, next_pslverr;
  qld_ctrl_s ctrl, next_ctrl;
  logic irq, next_irq;
  logic timer_done;
  logic energy_lost;
  logic [QLD_CAUSE_W-1:0] live_cause;
  logic [QLD_CAUSE_W-1:0] drop_hit;
  logic [QLD_ADDR_W-1:0] idx;
  logic access, wr, rd;
  logic hit_cfg, hit_thr, hit_c4, hit_sts, hit_mask;
  logic [15:0] cfg_word, thr_word, c4_word;

  qld_neg_timer #(
    .T11MS_CYC(T11MS_CYC),
    .T800US_CYC(T800US_CYC),
    .T2US_CYC(T2US_CYC),
    .T16MS_CYC(T16MS_CYC)
  ) u_timer (
    .clk_in(CORE_CLK_IN),
    .rst_n_in(RST_N_IN),
    .start_in(NEG_TIMER_START_IN),
    .sel_in(neg_sel),
    .done_out(timer_done)
  );

  assign energy_lost = (ENERGY_ACC_IN < thr);
  assign live_cause = cause_vec(CAUSE_IN, energy_lost);
  // cause counts only when enabled, quick drop on, and the link drops
  assign drop_hit = live_cause & src_sel &
                    {QLD_CAUSE_W{drop_en & CAUSE_IN.link_drop}};
  assign idx = PADDR_IN[QLD_ADDR_W+1:QLD_BYTE_SHIFT];
  assign access = PSEL_IN && PENABLE_IN && !pready;
  assign wr = access && PWRITE_IN && PSTRB_IN[0] && PSTRB_IN[1];
  assign rd = access && !PWRITE_IN;

  // register index decode
  always_comb begin
    hit_cfg = 1'b0;
    hit_thr = 1'b0;
    hit_c4 = 1'b0;
    hit_sts = 1'b0;
    hit_mask = 1'b0;
    if (idx == QLD_IDX_CFG) begin
      hit_cfg = 1'b1;
    end else if (idx == QLD_IDX_THR) begin
      hit_thr = 1'b1;
    end else if (idx == QLD_IDX_CONFIG_FOUR) begin
      hit_c4 = 1'b1;
    end else if (idx == QLD_IDX_IRQ_STS) begin
      hit_sts = 1'b1;
    end else if (idx == QLD_IDX_IRQ_MASK) begin
      hit_mask = 1'b1;
    end
  end

  always_comb begin
    cfg_word = '0;
    cfg_word[QLD_CFG_FORCE_BIT] = force_drop;
    cfg_word[QLD_CFG_EN_BIT] = drop_en;
    cfg_word[QLD_CFG_LATCH_LSB +: QLD_CAUSE_W] = latch;
    cfg_word[QLD_CFG_SRC_LSB +: QLD_CAUSE_W] = src_sel;
    thr_word = '0;
    thr_word[QLD_THR_RSVA_LSB +: QLD_THR_W] = thr_rsva;
    thr_word[QLD_THR_RSVB_LSB +: QLD_THR_W] = thr_rsvb;
    thr_word[QLD_THR_LSB +: QLD_THR_W] = thr;
    c4_word = QLD_C4_FIXED;
    c4_word[QLD_C4_RSV8_BIT] = c4_rsv8;
    c4_word[QLD_C4_TEST_BIT] = test_one;
    c4_word[QLD_C4_TIMER_LSB +: QLD_TIMER_W] = neg_sel;
    c4_word[QLD_C4_MIRROR_BIT] = mirror;
  end

  always_comb begin
    next_phase = phase;
    next_force_drop = force_drop;
    next_drop_en = drop_en;
    next_src_sel = src_sel;
    next_thr = thr;
    next_thr_rsva = thr_rsva;
    next_thr_rsvb = thr_rsvb;
    next_c4_rsv8 = c4_rsv8;
    next_test_one = test_one;
    next_neg_sel = neg_sel;
    next_mirror = mirror;
    next_irq_mask = irq_mask;
    next_irq_sts = irq_sts;
    next_latch = latch;
    next_pready = 1'b0;
    next_prdata = prdata;
    next_pslverr = 1'b0;
    // straps are caught once, in the second cycle after reset release
    case (phase)
      QLD_IDLE: begin
        next_phase = QLD_STRAP;
      end
      QLD_STRAP: begin
        next_test_one = TEST_MODE_STRAP_IN;
        next_mirror = MIRROR_STRAP_IN;
        next_thr = QUICK_DROP_STRAP_IN ? QLD_THR_STRAP_RESET : QLD_THR_RESET;
        next_drop_en = QUICK_DROP_STRAP_IN;
        next_phase = QLD_RUN;
      end
      default: begin
        next_phase = QLD_RUN;
      end
    endcase
    if (access) begin
      next_pready = 1'b1;
      if (hit_cfg) begin
        next_prdata = word_of(cfg_word);
        if (wr) begin
          next_force_drop = PWDATA_IN[QLD_CFG_FORCE_BIT];
          next_drop_en = PWDATA_IN[QLD_CFG_EN_BIT];
          next_src_sel = PWDATA_IN[QLD_CFG_SRC_LSB +: QLD_CAUSE_W];
        end
      end else if (hit_thr) begin
        next_prdata = word_of(thr_word);
        if (wr) begin
          next_thr = PWDATA_IN[QLD_THR_LSB +: QLD_THR_W];
          next_thr_rsva = PWDATA_IN[QLD_THR_RSVA_LSB +: QLD_THR_W];
          next_thr_rsvb = PWDATA_IN[QLD_THR_RSVB_LSB +: QLD_THR_W];
        end
      end else if (hit_c4) begin
        next_prdata = word_of(c4_word);
        if (wr) begin
          next_c4_rsv8 = PWDATA_IN[QLD_C4_RSV8_BIT];
          next_test_one = PWDATA_IN[QLD_C4_TEST_BIT];
          next_neg_sel = PWDATA_IN[QLD_C4_TIMER_LSB +: QLD_TIMER_W];
          next_mirror = PWDATA_IN[QLD_C4_MIRROR_BIT];
        end
      end else if (hit_sts) begin
        next_prdata = irq_word(irq_sts);
        if (wr) begin
          next_irq_sts = irq_sts & ~PWDATA_IN[QLD_IRQ_W-1:0];
        end
      end else if (hit_mask) begin
        next_prdata = irq_word(irq_mask);
        if (wr) begin
          next_irq_mask = PWDATA_IN[QLD_IRQ_W-1:0];
        end
      end else begin
        next_prdata = '0;
        next_pslverr = 1'b1;
      end
    end
    // read of the config register releases the latch to the live state
    if (rd && hit_cfg) begin
      next_latch = drop_hit;
    end else begin
      next_latch = latch | drop_hit;
    end
    // hardware set wins over a software clear
    next_irq_sts = next_irq_sts | {timer_done, drop_hit};
    next_ctrl.force_partner_drop = next_force_drop & ~SIGNAL_DETECT_IN;
    next_ctrl.quick_drop_active = next_drop_en;
    next_ctrl.test_mode = next_test_one;
    next_ctrl.mirror = next_mirror;
    next_ctrl.timer_done = timer_done;
    next_irq = |(next_irq_sts & next_irq_mask);
  end

  always_ff @(posedge CORE_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      phase <= QLD_IDLE;
      force_drop <= 1'b0;
      drop_en <= 1'b0;
      latch <= '0;
      src_sel <= '0;
      thr <= QLD_THR_RESET;
      thr_rsva <= QLD_THR_RSV_RESET;
      thr_rsvb <= QLD_THR_RSV_RESET;
      c4_rsv8 <= 1'b0;
      test_one <= 1'b0;
      neg_sel <= QLD_TIMER_RESET;
      mirror <= 1'b0;
      irq_sts <= '0;
      irq_mask <= '0;
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
      ctrl <= '0;
      irq <= 1'b0;
    end else begin
      phase <= next_phase;
      force_drop <= next_force_drop;
      drop_en <= next_drop_en;
      latch <= next_latch;
      src_sel <= next_src_sel;
      thr <= next_thr;
      thr_rsva <= next_thr_rsva;
      thr_rsvb <= next_thr_rsvb;
      c4_rsv8 <= next_c4_rsv8;
      test_one <= next_test_one;
      neg_sel <= next_neg_sel;
      mirror <= next_mirror;
      irq_sts <= next_irq_sts;
      irq_mask <= next_irq_mask;
      pready <= next_pready;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      ctrl <= next_ctrl;
      irq <= next_irq;
    end
  end

  assign PREADY_OUT = pready;
  assign PRDATA_OUT = prdata;
  assign PSLVERR_OUT = pslverr;
  assign CTRL_OUT = ctrl;
  assign CAUSE_LATCH_OUT = latch;
  assign IRQ_OUT = irq;
endmodule
`default_nettype wire

// ==== qld_regs_props.sv ====
/*
  qld_regs_props: concurrent checks on the ports of the register block.
  assumes: bound to every qld_regs instance, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module qld_regs_props
  import qld_pkg::*;
(
  input wire logic CORE_CLK_IN,
  input wire logic RST_N_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [QLD_ADDR_W+1:0] PADDR_IN,
  input wire logic PREADY_OUT,
  input wire logic [QLD_DATA_W-1:0] PRDATA_OUT,
  input wire logic PSLVERR_OUT,
  input wire qld_cause_s CAUSE_IN,
  input wire logic SIGNAL_DETECT_IN,
  input wire qld_ctrl_s CTRL_OUT,
  input wire logic [QLD_CAUSE_W-1:0] CAUSE_LATCH_OUT
);
  default clocking @(posedge CORE_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  logic [QLD_ADDR_W-1:0] idx;
  logic mapped;
  logic rd_cfg;
  logic rd_ans;
  assign idx = PADDR_IN[QLD_ADDR_W+1:2];
  assign mapped = idx inside {QLD_IDX_CFG, QLD_IDX_THR, QLD_IDX_CONFIG_FOUR, QLD_IDX_IRQ_STS,
    QLD_IDX_IRQ_MASK};
  assign rd_cfg = PSEL_IN && PENABLE_IN && !PREADY_OUT && !PWRITE_IN && idx == QLD_IDX_CFG;
  assign rd_ans = PREADY_OUT && !PWRITE_IN;
  sequence s_take;
    PSEL_IN && PENABLE_IN && !PREADY_OUT;
  endsequence
  sequence s_answer;
    PREADY_OUT ##1 !PREADY_OUT;
  endsequence
  property p_answer;
    s_take |=> s_answer;
  endproperty
  a_answer: assert property (p_answer) else $error("answer not one cycle after request");
  property p_err_map;
    PREADY_OUT |-> (PSLVERR_OUT == !mapped);
  endproperty
  a_err_map: assert property (p_err_map) else $error("slave error does not match map");
  property p_rdata_hold;
    $changed(PRDATA_OUT) |-> PREADY_OUT;
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without answer");
  property p_config_four_fixed;
    rd_ans && idx == QLD_IDX_CONFIG_FOUR |-> (PRDATA_OUT & 32'hFFFF_FE1E) == 32'h0000_1010;
  endproperty
  a_config_four_fixed: assert property (p_config_four_fixed) else $error("fixed bits of config_four wrong");
  property p_thr_rsv;
    rd_ans && idx == QLD_IDX_THR |-> (PRDATA_OUT & 32'hFFFF_F888) == 32'h0;
  endproperty
  a_thr_rsv: assert property (p_thr_rsv) else $error("threshold read-only bits not zero");
  property p_force;
    CTRL_OUT.force_partner_drop |-> $past(!SIGNAL_DETECT_IN);
  endproperty
  a_force: assert property (p_force) else $error("partner drop while signal present");
  property p_latch_rise;
    (CAUSE_LATCH_OUT & ~$past(CAUSE_LATCH_OUT)) != 5'h0 |->
      $past(CAUSE_IN.link_drop, 1) || $past(CAUSE_IN.link_drop, 2);
  endproperty
  a_latch_rise: assert property (p_latch_rise) else $error("latch set without drop");
  property p_latch_hold;
    (~CAUSE_LATCH_OUT & $past(CAUSE_LATCH_OUT)) != 5'h0 |->
      $past(rd_cfg, 1) || $past(rd_cfg, 2) || $past(rd_cfg, 3);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latch fell without read");
  property p_tdone;
    CTRL_OUT.timer_done |=> !CTRL_OUT.timer_done;
  endproperty
  a_tdone: assert property (p_tdone) else $error("timer done longer than one cycle");
endmodule
bind qld_regs qld_regs_props u_props (.CORE_CLK_IN(CORE_CLK_IN), .RST_N_IN(RST_N_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .CAUSE_IN(CAUSE_IN), .SIGNAL_DETECT_IN(SIGNAL_DETECT_IN), .CTRL_OUT(CTRL_OUT),
  .CAUSE_LATCH_OUT(CAUSE_LATCH_OUT));
`default_nettype wire

// ==== testbench.sv ====
/*
  testbench: APB master and line-side model around qld_regs, queued read checks.
  assumes: small timer parameters, 100 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench
  import qld_pkg::*;
;
  localparam int unsigned T11 = 40, T800 = 30, T2 = 5, T16 = 50;
  logic clk = 0, rst_n = 0, psel = 0, pen = 0, pwr = 0, qs = 0, ts = 0, ms = 0;
  logic start = 0, sig = 1, drop = 0, sigd, up, pready, pslverr, irq;
  logic [13:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic [4:0] creq = '0, latch;
  logic [2:0] areq = 3'h7, acc;
  qld_cause_s cause;
  qld_ctrl_s ctrl;
  logic [33:0] q[$];
  int failures = 0, num_checks = 0, seed = 15;
  always #5 clk = ~clk;
  qld_regs #(.T11MS_CYC(T11), .T800US_CYC(T800), .T2US_CYC(T2), .T16MS_CYC(T16)) u_dut (
    .CORE_CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(4'hF), .PREADY_OUT(pready),
    .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr), .CAUSE_IN(cause), .ENERGY_ACC_IN(acc),
    .SIGNAL_DETECT_IN(sigd), .QUICK_DROP_STRAP_IN(qs), .TEST_MODE_STRAP_IN(ts),
    .MIRROR_STRAP_IN(ms), .NEG_TIMER_START_IN(start), .CTRL_OUT(ctrl),
    .CAUSE_LATCH_OUT(latch), .IRQ_OUT(irq));
  qld_link_model u_link (.clk_in(clk), .rst_n_in(rst_n), .cause_req_in(creq), .drop_in(drop),
    .acc_req_in(areq), .sig_req_in(sig), .force_in(ctrl.force_partner_drop),
    .cause_out(cause), .acc_out(acc), .sig_out(sigd), .partner_up_out(up));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic e, input logic [31:0] x);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1;
    pwr <= w;
    paddr <= {a, 2'b00};
    pwdata <= d;
    q.push_back({w, e, x});
    @(posedge clk);
    pen <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      chk("apb answer", 1, 0);
      final_report();
    end
    psel <= 0;
    pen <= 0;
  endtask
  always @(posedge clk) begin
    if (pready === 1'b1) begin
      if (q.size() == 0) begin
        chk("queue", 1, 0);
      end else begin
        if (!q[0][33]) chk("read data", q[0][31:0], prdata);
        chk("slave error", {31'h0, q[0][32]}, {31'h0, pslverr});
        void'(q.pop_front());
      end
    end
  end
  task automatic rst(input logic a, input logic b, input logic c);
    @(posedge clk);
    rst_n <= 0;
    qs <= a;
    ts <= b;
    ms <= c;
    repeat (12) @(posedge clk);
    rst_n <= 1;
    repeat (4) @(posedge clk);
  endtask
  task automatic final_report;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    failures++;
    final_report();
  end
  initial begin
    logic [4:0] src, e, c;
    logic en;
    int n;
    int lim[4];
    lim = '{T16, T2, T800, T11};
    rst(0, 1, 1);
    apb(0, QLD_IDX_CFG, 0, 0, 32'h0);
    apb(0, QLD_IDX_THR, 0, 0, 32'h221);
    apb(0, QLD_IDX_CONFIG_FOUR, 0, 0, 32'h10B1);
    chk("test mode", 1, ctrl.test_mode);
    chk("mirror", 1, ctrl.mirror);
    chk("drop active", 0, ctrl.quick_drop_active);
    apb(1, QLD_IDX_CONFIG_FOUR, 32'hFFFF, 0, 0);
    apb(0, QLD_IDX_CONFIG_FOUR, 0, 0, 32'h11F1);
    apb(1, QLD_IDX_CONFIG_FOUR, 0, 0, 0);
    apb(0, QLD_IDX_CONFIG_FOUR, 0, 0, 32'h1010);
    chk("test mode", 0, ctrl.test_mode);
    chk("mirror", 0, ctrl.mirror);
    apb(1, QLD_IDX_THR, 32'hFFFF, 0, 0);
    apb(0, QLD_IDX_THR, 0, 0, 32'h777);
    apb(1, QLD_IDX_THR, 32'h221, 0, 0);
    apb(0, 12'h030, 0, 1, 32'h0);
    apb(1, 12'h030, 32'hFFFF, 1, 0);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      apb(1, QLD_IDX_CONFIG_FOUR, s << 5, 0, 0);
      @(posedge clk);
      start <= 1;
      @(posedge clk);
      start <= 0;
      n = 0;
      while (ctrl.timer_done !== 1'b1 && n < 200) begin
        @(posedge clk);
        n++;
      end
      chk("timer span", 1, {31'h0, n + 1 >= lim[s] && n <= lim[s] + 2});
    end
    chk("irq masked", 0, irq);
    apb(1, QLD_IDX_IRQ_MASK, 32'h20, 0, 0);
    repeat (2) @(posedge clk);
    chk("irq raised", 1, irq);
    apb(1, QLD_IDX_IRQ_STS, 32'h20, 0, 0);
    repeat (2) @(posedge clk);
    chk("irq cleared", 0, irq);
    $display("test timer done");
    for (int k = 0; k < 3; k++) begin
      src = $random(seed);
      c = $random(seed);
      en = k < 2;
      e = en ? (src & {c[4:1], k == 0}) : 5'h0;
      apb(1, QLD_IDX_CFG, {16'h0, 1'b0, en, 9'h0, src}, 0, 0);
      creq <= {c[4:1], 1'b0};
      areq <= k[2:0];
      drop <= 1;
      repeat (3) @(posedge clk);
      creq <= 0;
      drop <= 0;
      areq <= 3'h7;
      repeat (3) @(posedge clk);
      chk("latch", {27'h0, e}, {27'h0, latch});
      apb(0, QLD_IDX_CFG, 0, 0, {16'h0, 1'b0, en, 1'b0, e, 3'h0, src});
      apb(0, QLD_IDX_CFG, 0, 0, {16'h0, 1'b0, en, 9'h0, src});
      apb(1, QLD_IDX_IRQ_STS, 32'h1F, 0, 0);
    end
    $display("test causes done");
    apb(1, QLD_IDX_CFG, 32'h8000, 0, 0);
    sig <= 0;
    repeat (4) @(posedge clk);
    chk("force drop", 1, ctrl.force_partner_drop);
    chk("partner up", 0, up);
    sig <= 1;
    repeat (4) @(posedge clk);
    chk("force drop", 0, ctrl.force_partner_drop);
    chk("partner up", 1, up);
    rst(1, 0, 0);
    apb(0, QLD_IDX_CFG, 0, 0, 32'h4000);
    chk("drop active", 1, ctrl.quick_drop_active);
    apb(0, QLD_IDX_THR, 0, 0, 32'h222);
    apb(0, QLD_IDX_CONFIG_FOUR, 0, 0, 32'h1030);
    apb(1, QLD_IDX_THR, 32'h221, 0, 0);
    apb(0, QLD_IDX_THR, 0, 0, 32'h221);
    $display("test strap done");
    final_report();
  end
endmodule
`default_nettype wire
